// ==== iosb_regs.sv ====
// slot configuration, memory parity fault capture, arbitration enables and bypass address path
// Overview of operation
// [RULE_01] slot config bit 16 supplies physical bit 30 for bypassed accesses
// [RULE_02] slot config bit 2 set means slave takes 16-byte bursts
// [RULE_03] slot config bit 1 set means slave takes 8-byte bursts
// [RULE_04] bypass bit set and top bits 00: pa30 from segment, pa29:0 from address
// [RULE_05] fifth preset device configuration is a fixed constant
// [RULE_06] slot config unused bits read zero; software writes zero
// [RULE_07] fault status reloads per memory request, locks on error until read
// [RULE_08] status bit 31 summarises the two parity error bits
// [RULE_09] status bit 24 records supervisor mode at the error
// [RULE_10] status bit 23 records processor-initiated faulting transaction
// [RULE_11] status bit 19 flags a further error after the captured one
// [RULE_12] status bits 14 and 13 flag even and odd word parity errors
// [RULE_13] status bit 12 records boot mode at the error
// [RULE_14] status bit 11 is pte cacheable for processor requests, else zero
// [RULE_15] status bits 7:4 hold the faulting request type code
// [RULE_16] fault address captures 31-bit request address, locks like status, bit 31 zero
// [RULE_17] bits 20:16 enable arbitration, top bit for preset device
// [RULE_18] identifier bits 3:0 are constant and ignore writes
// [RULE_19] bypassed address outside main memory returns error to master
// [RULE_20] fault status reserved bits read zero; software writes zero
// [RULE_21] identifier register unused bits read zero; software writes zero
// [RULE_22] software reaches registers in control space with pa 30:24 equal 0x10
// [RULE_23] bypass uses the slot config of the currently granted master
// [RULE_24] a master with clear arbitration enable is never granted
module iosb_regs
  import iosb_pkg::*;
#(
  parameter logic [30:0] MEM_LIMIT = MEM_LIMIT_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input iosb_pkg::iosb_reg_req_t reg_req,
  output iosb_pkg::iosb_reg_rsp_t reg_rsp,
  input iosb_pkg::iosb_mem_req_t mem_req,
  input wire logic [4:0] arb_request,
  output logic [4:0] arb_grant,
  input iosb_pkg::iosb_dma_req_t dma_req,
  output iosb_pkg::iosb_dma_rsp_t dma_rsp,
  output logic [4:0] arbitration_enable_bits
);
  import iosb_pkg::*;

  typedef struct packed {
    logic [3:0][31:0] slot_cfg;
    logic [31:0] fstat;
    logic [30:0] faddr;
    logic locked;
    logic [4:0] arb_en;
    logic [4:0] grant;
    logic [2:0] rr_ptr;
    iosb_reg_rsp_t rsp;
    iosb_dma_rsp_t dma;
  } iosb_state_t;

  iosb_state_t state_r;
  iosb_state_t state_nxt;

  function automatic logic hit(input logic [30:0] a, input logic [30:0] off);
    return a == off;
  endfunction : hit

  function automatic logic [31:0] slot_cfg_of(input iosb_state_t s, input logic [2:0] idx);
    logic [31:0] v;
    v = PRESET_DEV_CFG; // [RULE_05]
    if (idx < 3'(NUM_SLOTS)) begin
      v = s.slot_cfg[idx[1:0]];
    end
    return v;
  endfunction : slot_cfg_of

  logic [2:0] grant_idx;
  logic [30:0] bypass_pa;
  logic [31:0] cfg_sel;
  logic err_now;
  logic in_space;
  logic [2:0] cand;
  // four bits so that pointer plus offset cannot wrap before the modulo step
  logic [3:0] cand_sum;

  always_comb begin
    state_nxt = state_r;
    state_nxt.rsp.ack = 1'b0;
    state_nxt.dma = '0;
    in_space = reg_req.addr[30:24] == CTRL_SPACE_SEL; // [RULE_22]
    // register access
    if (reg_req.req && in_space) begin
      state_nxt.rsp.ack = 1'b1;
      state_nxt.rsp.rdata = 32'h0000_0000;
      if (reg_req.wr) begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
          if (hit(reg_req.addr, OFF_SLOT0 + 31'(4 * i))) begin
            state_nxt.slot_cfg[i] = reg_req.wdata & SLOT_CFG_MASK; // [RULE_06]
          end
        end
        if (hit(reg_req.addr, OFF_MID)) begin
          state_nxt.arb_en = reg_req.wdata[ARB_EN_LO +: NUM_DEV]; // [RULE_17] [RULE_18]
        end
      end else begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
          if (hit(reg_req.addr, OFF_SLOT0 + 31'(4 * i))) begin
            state_nxt.rsp.rdata = state_r.slot_cfg[i];
          end
        end
        if (hit(reg_req.addr, OFF_FSTAT)) begin
          state_nxt.rsp.rdata = state_r.fstat;
        end
        if (hit(reg_req.addr, OFF_FADDR)) begin
          state_nxt.rsp.rdata = {1'b0, state_r.faddr}; // [RULE_16]
        end
        if (hit(reg_req.addr, OFF_MID)) begin
          state_nxt.rsp.rdata = {11'h000, state_r.arb_en, 12'h000, MODULE_ID_VALUE}; // [RULE_18] [RULE_21]
        end
      end
    end
    // memory fault capture; a read releases the lock, and an error in the same cycle sets bit 19 but does not relock
    if (reg_req.req && in_space && !reg_req.wr &&
        (hit(reg_req.addr, OFF_FSTAT) || hit(reg_req.addr, OFF_FADDR))) begin
      state_nxt.locked = 1'b0; // [RULE_07]
    end
    err_now = mem_req.valid && (mem_req.pe_even || mem_req.pe_odd);
    if (mem_req.valid) begin
      if (!state_r.locked) begin
        state_nxt.fstat = 32'h0000_0000; // [RULE_20]
        state_nxt.fstat[FS_ERR] = err_now; // [RULE_08]
        state_nxt.fstat[FS_SUP] = mem_req.supervisor; // [RULE_09]
        state_nxt.fstat[FS_CPU] = mem_req.cpu_origin; // [RULE_10]
        state_nxt.fstat[FS_PE_EVEN] = mem_req.pe_even; // [RULE_12]
        state_nxt.fstat[FS_PE_ODD] = mem_req.pe_odd; // [RULE_12]
        state_nxt.fstat[FS_BOOT] = mem_req.boot_phase; // [RULE_13]
        state_nxt.fstat[FS_CACHE] = mem_req.cpu_origin & mem_req.cacheable; // [RULE_14]
        state_nxt.fstat[FS_TYPE_LO +: 4] = mem_req.req_type; // [RULE_15]
        state_nxt.faddr = mem_req.phys_addr; // [RULE_16]
        state_nxt.locked = err_now; // [RULE_07]
      end else if (err_now) begin
        // set wins over the releasing read, so bit 19 stays set until the next unlocked request reloads the status
        state_nxt.fstat[FS_MULT] = 1'b1; // [RULE_11]
      end
    end
    // arbitration: round robin over enabled requesters, grant held while requested
    cand = state_r.rr_ptr;
    cand_sum = 4'h0;
    state_nxt.grant = state_r.grant & arb_request & state_r.arb_en; // [RULE_24]
    if (state_nxt.grant == 5'h00) begin
      for (int k = 0; k < NUM_DEV; k++) begin
        cand_sum = 4'(state_r.rr_ptr) + 4'(k);
        cand = (cand_sum >= 4'(NUM_DEV)) ? 3'(cand_sum - 4'(NUM_DEV)) : 3'(cand_sum);
        if (state_nxt.grant == 5'h00 && arb_request[cand] && state_r.arb_en[cand]) begin // [RULE_24]
          state_nxt.grant = 5'(1) << cand;
          state_nxt.rr_ptr = (cand == 3'(NUM_DEV - 1)) ? 3'h0 : cand + 3'h1;
        end
      end
    end
    // bypass path for the granted master
    grant_idx = 3'h0;
    for (int k = 0; k < NUM_DEV; k++) begin
      if (state_r.grant[k]) begin
        grant_idx = 3'(k);
      end
    end
    cfg_sel = slot_cfg_of(state_r, grant_idx); // [RULE_23]
    bypass_pa = {cfg_sel[SC_SEG], dma_req.vaddr[29:0]}; // [RULE_01] [RULE_04]
    if (dma_req.valid && state_r.grant != 5'h00) begin
      state_nxt.dma.valid = 1'b1;
      state_nxt.dma.burst16_ok = cfg_sel[SC_B16]; // [RULE_02]
      state_nxt.dma.burst8_ok = cfg_sel[SC_B8]; // [RULE_03]
      if (cfg_sel[SC_BYP] && dma_req.vaddr[31:30] == BYPASS_TOP) begin // [RULE_04]
        state_nxt.dma.bypass = 1'b1;
        state_nxt.dma.phys_addr = bypass_pa;
        state_nxt.dma.error = bypass_pa >= MEM_LIMIT; // [RULE_19]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        state_r.slot_cfg[i] <= SLOT_CFG_RESET;
      end
      state_r.arb_en <= ARB_EN_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rsp = state_r.rsp;
  assign dma_rsp = state_r.dma;
  assign arb_grant = state_r.grant;
  assign arbitration_enable_bits = state_r.arb_en;
endmodule : iosb_regs

// ==== iosb_pkg.sv ====
// package: register map, field positions and carriers for the slot, fault and arbitration register bank
package iosb_pkg;
  localparam int unsigned NUM_SLOTS = 4;
  localparam int unsigned NUM_DEV = 5;
  localparam logic [6:0] CTRL_SPACE_SEL = 7'h10;
  localparam logic [30:0] OFF_SLOT0 = 31'h1000_1010;
  localparam logic [30:0] OFF_SLOT1 = 31'h1000_1014;
  localparam logic [30:0] OFF_SLOT2 = 31'h1000_1018;
  localparam logic [30:0] OFF_SLOT3 = 31'h1000_101c;
  localparam logic [30:0] OFF_FSTAT = 31'h1000_1020;
  localparam logic [30:0] OFF_FADDR = 31'h1000_1024;
  localparam logic [30:0] OFF_MID = 31'h1000_2000;
  localparam int unsigned SC_SEG = 16;
  localparam int unsigned SC_B16 = 2;
  localparam int unsigned SC_B8 = 1;
  localparam int unsigned SC_BYP = 0;
  localparam logic [31:0] SLOT_CFG_MASK = 32'h0001_0007;
  localparam logic [31:0] SLOT_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] PRESET_DEV_CFG = 32'h0000_0002;
  localparam int unsigned FS_ERR = 31;
  localparam int unsigned FS_SUP = 24;
  localparam int unsigned FS_CPU = 23;
  localparam int unsigned FS_MULT = 19;
  localparam int unsigned FS_PE_EVEN = 14;
  localparam int unsigned FS_PE_ODD = 13;
  localparam int unsigned FS_BOOT = 12;
  localparam int unsigned FS_CACHE = 11;
  localparam int unsigned FS_TYPE_LO = 4;
  localparam int unsigned ARB_EN_LO = 16;
  localparam logic [4:0] ARB_EN_RESET = 5'h00;
  // module identifier: value arbitrary
  localparam logic [3:0] MODULE_ID_VALUE = 4'h3;
  localparam logic [30:0] MEM_LIMIT_DEFAULT = 31'h0400_0000;
  localparam logic [1:0] BYPASS_TOP = 2'h0;

  typedef enum logic [3:0] {
    REQ_NONE = 4'h0,
    READ_TWO_WORDS = 4'h1,
    READ_FOUR_WORDS = 4'h2,
    READ_EIGHT_WORDS = 4'h4,
    WRITE_ONE_BYTE = 4'h9,
    WRITE_TWO_BYTES = 4'ha,
    WRITE_ONE_WORD = 4'hb,
    WRITE_TWO_WORDS = 4'hc
  } iosb_req_type_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [30:0] addr;
    logic [31:0] wdata;
  } iosb_reg_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } iosb_reg_rsp_t;

  typedef struct packed {
    logic valid;
    logic [30:0] phys_addr;
    logic [3:0] req_type;
    logic cpu_origin;
    logic supervisor;
    logic cacheable;
    logic boot_phase;
    logic pe_even;
    logic pe_odd;
  } iosb_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
  } iosb_dma_req_t;

  typedef struct packed {
    logic valid;
    logic bypass;
    logic error;
    logic [30:0] phys_addr;
    logic burst16_ok;
    logic burst8_ok;
  } iosb_dma_rsp_t;
endpackage : iosb_pkg

// ==== iosb_monitor.sv ====
// checker: port relations of the slot, fault and arbitration register bank
module iosb_monitor
  import iosb_pkg::*;
#(
  parameter logic [30:0] MEM_LIMIT = MEM_LIMIT_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input iosb_pkg::iosb_reg_req_t reg_req,
  input iosb_pkg::iosb_reg_rsp_t reg_rsp,
  input iosb_pkg::iosb_mem_req_t mem_req,
  input wire logic [4:0] arb_request,
  input wire logic [4:0] arb_grant,
  input iosb_pkg::iosb_dma_req_t dma_req,
  input iosb_pkg::iosb_dma_rsp_t dma_rsp,
  input wire logic [4:0] arbitration_enable_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [30:0] a);
    reg_req.req && !reg_req.wr && reg_req.addr == a ##1 reg_rsp.ack;
  endsequence
  property p_ack; reg_req.req && reg_req.addr[30:24] == CTRL_SPACE_SEL |=> reg_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("control space access not acknowledged");
  // grant is registered, so it answers to the enables of one edge earlier
  property p_grant; (arb_grant & ~$past(arbitration_enable_bits)) == 5'h00; endproperty
  a_grant: assert property (p_grant) else $error("disabled device granted");
  property p_byp; dma_rsp.valid && dma_rsp.bypass |-> $past(dma_req.vaddr[31:30]) == BYPASS_TOP
    && dma_rsp.phys_addr[29:0] == $past(dma_req.vaddr[29:0]); endproperty
  a_byp: assert property (p_byp) else $error("bypass address wrong");
  property p_err; dma_rsp.valid && dma_rsp.bypass |-> dma_rsp.error == (dma_rsp.phys_addr >= MEM_LIMIT); endproperty
  a_err: assert property (p_err) else $error("bypass range error wrong");
  property p_fse; s_rd(OFF_FSTAT) |-> reg_rsp.rdata[31] == (reg_rsp.rdata[14] | reg_rsp.rdata[13]); endproperty
  a_fse: assert property (p_fse) else $error("summary flag wrong");
  property p_fsr; s_rd(OFF_FSTAT) |-> (reg_rsp.rdata & 32'h7e77_870f) == 32'h0; endproperty
  a_fsr: assert property (p_fsr) else $error("status reserved bits set");
  property p_fa; s_rd(OFF_FADDR) |-> !reg_rsp.rdata[31]; endproperty
  a_fa: assert property (p_fa) else $error("fault address top bit set");
  property p_mid; s_rd(OFF_MID) |-> reg_rsp.rdata == {11'h0, arbitration_enable_bits, 12'h0, MODULE_ID_VALUE}; endproperty
  a_mid: assert property (p_mid) else $error("identifier register wrong");
endmodule : iosb_monitor

// ==== iosb_dma_partner.sv ====
// model of the peripheral bus masters: request level, an address on every second cycle while granted
module iosb_dma_partner
  import iosb_pkg::*;
(
  input wire logic clk,
  input wire logic [4:0] want,
  input wire logic [31:0] va,
  input wire logic [4:0] arb_grant,
  output logic [4:0] arb_request,
  output iosb_pkg::iosb_dma_req_t dma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    arb_request = 5'h00;
    dma_req = '0;
  end
  // idle address lines show the inverse so a stale value never looks live
  always @(posedge clk) begin
    arb_request <= want;
    dma_req.valid <= |(arb_grant & want) && !dma_req.valid;
    dma_req.vaddr <= (|(arb_grant & want) && !dma_req.valid) ? va : ~va;
  end
endmodule : iosb_dma_partner

// ==== iosb_regs_tb_top.sv ====
// testbench: register access, parity fault capture and bypass path
module iosb_regs_tb_top import iosb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [30:0] LIMIT = 31'h4000_2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  iosb_reg_req_t reg_req = '0;
  iosb_reg_rsp_t reg_rsp;
  iosb_mem_req_t mem_req = '0;
  iosb_dma_req_t dma_req;
  iosb_dma_rsp_t dma_rsp;
  logic [4:0] arb_request, arb_grant, en, g;
  logic [4:0] want = 5'h00;
  logic [31:0] va = 32'h0;
  logic [31:0] q;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  iosb_regs #(.MEM_LIMIT(LIMIT)) iosb_regs_i(.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .mem_req(mem_req), .arb_request(arb_request), .arb_grant(arb_grant), .dma_req(dma_req),
    .dma_rsp(dma_rsp), .arbitration_enable_bits(en));
  iosb_dma_partner iosb_dma_partner_i(.clk(clk), .want(want), .va(va), .arb_grant(arb_grant),
    .arb_request(arb_request), .dma_req(dma_req));
  task stop_test;
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [35:0] s, input logic [35:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task acc(input logic w, input logic [30:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_req = '{1'b1, w, a, d};
    @(negedge clk);
    reg_req.req = 1'b0;
    q = reg_rsp.rdata;
    chk("ack", reg_rsp.ack, 1'b1);
  endtask : acc
  task t_dma(input logic [4:0] dv, input logic [31:0] a);
    g = 5'h00;
    want = dv;
    va = a;
    repeat (20) begin
      @(negedge clk);
      g = g | arb_grant;
      if (dma_rsp.valid === 1'b1) break;
    end
    want = 5'h00;
  endtask : t_dma
  task t_slots;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, OFF_SLOT0 + 31'(4 * i), 32'hffff_ffff);
      acc(1'b0, OFF_SLOT0 + 31'(4 * i), 32'h0);
      chk("slot", q, SLOT_CFG_MASK);
    end
    acc(1'b1, OFF_MID, 32'hffff_ffff);
    acc(1'b0, OFF_MID, 32'h0);
    chk("mid", q, {11'h0, 5'h1f, 12'h0, MODULE_ID_VALUE});
    acc(1'b0, OFF_MID + 31'h4, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask : t_slots
  task t_fault;
    @(negedge clk);
    mem_req = '{1'b1, 31'h0123_4560, WRITE_ONE_BYTE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    @(negedge clk);
    mem_req = '{1'b1, 31'h0765_4320, READ_TWO_WORDS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    @(negedge clk);
    mem_req = '0;
    acc(1'b0, OFF_FADDR, 32'h0);
    chk("faddr", q, 32'h0123_4560);
    acc(1'b0, OFF_FSTAT, 32'h0);
    chk("fstat", q, 32'h8188_5890);
    acc(1'b1, OFF_FSTAT, 32'hffff_ffff);
    mem_req = '{1'b1, 31'h0000_0abc, READ_TWO_WORDS, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    @(negedge clk);
    mem_req = '0;
    acc(1'b0, OFF_FSTAT, 32'h0);
    chk("reload", q, 32'h0000_0010);
    acc(1'b0, OFF_FADDR, 32'h0);
    chk("readdr", q, 32'h0000_0abc);
  endtask : t_fault
  task t_bypass;
    acc(1'b1, OFF_MID, 32'h0012_0000);
    acc(1'b1, OFF_SLOT1, 32'h0001_0005);
    t_dma(5'h01, 32'h0);
    chk("grant", g, 5'h00);
    t_dma(5'h02, 32'h0000_1234);
    chk("byp", dma_rsp[35:0], {3'b110, 31'h4000_1234, 2'b10});
    t_dma(5'h02, 32'h0000_3000);
    chk("range", dma_rsp[35:0], {3'b111, 31'h4000_3000, 2'b10});
    t_dma(5'h10, 32'h0000_0100);
    chk("dev4", {dma_rsp.valid, dma_rsp.bypass, dma_rsp.burst16_ok, dma_rsp.burst8_ok}, 4'b1001);
  endtask : t_bypass
  // ceiling well above the fewer than one hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_slots;
    t_fault;
    t_bypass;
    stop_test;
  end
endmodule : iosb_regs_tb_top
bind iosb_regs iosb_monitor #(.MEM_LIMIT(MEM_LIMIT)) iosb_monitor_i(.clk(clk), .rst(rst), .reg_req(reg_req),
  .reg_rsp(reg_rsp), .mem_req(mem_req), .arb_request(arb_request), .arb_grant(arb_grant), .dma_req(dma_req),
  .dma_rsp(dma_rsp), .arbitration_enable_bits(arbitration_enable_bits));
